// ---- hdl/tbsl_exerciser.sv ----
// Target bus scope loop exerciser with AXI4-Lite register access
// Contract
// (R1) Poke loop writes same data to one memory address under selected status space.
// (R2) Every loop has an I/O-space variant issuing the same sequence as I/O cycles.
// (R3) Alternate loop writes pattern then its full-width complement, forever.
// (R4) Rotate loop rotates pattern left one bit within access width, each write.
// (R5) Write-then-read loop writes data then reads the same address, forever.
// (R6) Incrementing loop writes a value rising by one each write.
// (R7) Range loop reads from lowest address, then one higher each cycle.
// (R8) After the last range address, reading restarts at the range start.
// (R9) Toggle loop writes zero then user data, alternating forever.
// (R10) Byte mode uses 8-bit values, word mode 16-bit, for all patterns.
// (R11) Loops and self-check start only while paused, otherwise rejected.
// (R12) Host stops a loop only by its abort character.
// (R13) Self-check computes firmware CRC once and flags an error on mismatch.
// (R14) Abort ends loop after the current bus cycle, back to idle.
`timescale 1ns/100ps
`default_nettype none
`include "tbsl_regs.svh"
module tbsl_exerciser
    import tbsl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic paused,
    output logic busReq,
    output logic busWrite,
    output logic busIo,
    output logic busWord,
    output logic [2:0] memory_space_select,
    output logic [19:0] busAddr,
    output logic [15:0] busWdata,
    input wire logic busAck,
    output logic [11:0] fwAddr,
    input wire logic [7:0] fwData
);
    tbsl_state_t state_q;
    logic [31:0] ctrl_q;
    logic [19:0] addr_q;
    logic [19:0] end_q;
    logic [15:0] data_q;
    logic [15:0] cref_q;
    logic [15:0] crc_q;
    logic [5:0] cmd_q;
    logic phase_q;
    logic rejected_q;
    logic crcErr_q;
    logic crcDone_q;
    logic abortPend_q;
    logic awGot_q;
    logic wGot_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic doWrite;
    logic mapped;
    logic startReq;
    logic abortReq;
    logic [5:0] baseCmd;
    logic [31:0] ctrlIn;
    logic [15:0] mask;
    logic [15:0] crcNext;
    logic ack;

    // Write channels may arrive in either order; latch each until both are here
    assign s_axi_awready = !awGot_q && !s_axi_bvalid;
    assign s_axi_wready = !wGot_q && !s_axi_bvalid;
    assign wa = awGot_q ? awAddr_q : s_axi_awaddr;
    assign wd = wGot_q ? wData_q : s_axi_wdata;
    assign ws = wGot_q ? wStrb_q : s_axi_wstrb;
    assign doWrite = (awGot_q || (s_axi_awvalid && s_axi_awready))
        && (wGot_q || (s_axi_wvalid && s_axi_wready));
    assign mapped = (wa <= `TBSL_OFF_CREF) && (wa[1:0] == 2'h0);
    assign startReq = doWrite && (wa == `TBSL_OFF_CTRL) && ws[1] && wd[`TBSL_CTRL_START];
    assign abortReq = doWrite && (wa == `TBSL_OFF_CTRL) && ws[1] && wd[`TBSL_CTRL_ABORT];
    assign baseCmd = (ctrlIn[5:0] >= `TBSL_IO_BASE) ? ctrlIn[5:0] - `TBSL_IO_BASE : ctrlIn[5:0];

    // Byte lane merge under write strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Control word as it stands after this write, so a start runs the command written with it
    assign ctrlIn = merge(ctrl_q, wd, ws) & 32'h0000_3c3f;

    // Write address/data latches and response
    always_ff @(posedge mclk) begin
        if (rst) begin
            awGot_q <= 1'b0;
            wGot_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TBSL_RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q <= s_axi_awaddr;
                awGot_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                wGot_q <= 1'b1;
            end
            if (doWrite) begin
                awGot_q <= 1'b0;
                wGot_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped ? `TBSL_RESP_OK : `TBSL_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers; start and abort bits are pulses, not stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_q <= `TBSL_CTRL_RST;
            addr_q <= 20'h00000;
            end_q <= 20'h00000;
            data_q <= 16'h0000;
            cref_q <= 16'h0000;
        end else if (doWrite) begin
            case (wa)
                `TBSL_OFF_CTRL: ctrl_q <= ctrlIn;
                `TBSL_OFF_ADDR: addr_q <= 20'(merge({12'h000, addr_q}, wd, ws));
                `TBSL_OFF_DATA: data_q <= 16'(merge({16'h0000, data_q}, wd, ws));
                `TBSL_OFF_END: end_q <= 20'(merge({12'h000, end_q}, wd, ws));
                `TBSL_OFF_CREF: cref_q <= 16'(merge({16'h0000, cref_q}, wd, ws));
                default: ;
            endcase
        end
    end

    // Read channel; one read at a time, unmapped answers SLVERR
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TBSL_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TBSL_RESP_OK;
            case (s_axi_araddr)
                `TBSL_OFF_CTRL: s_axi_rdata <= ctrl_q;
                `TBSL_OFF_ADDR: s_axi_rdata <= {12'h000, addr_q};
                `TBSL_OFF_DATA: s_axi_rdata <= {16'h0000, data_q};
                `TBSL_OFF_END: s_axi_rdata <= {12'h000, end_q};
                `TBSL_OFF_STAT: s_axi_rdata <= {28'h0000000, crcDone_q, crcErr_q, rejected_q,
                                                state_q != TBSL_IDLE};
                `TBSL_OFF_CREF: s_axi_rdata <= {16'h0000, cref_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `TBSL_RESP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign mask = busWord ? 16'hffff : 16'h00ff; // (R10)
    assign busReq = (state_q == TBSL_BUS);
    assign ack = busReq && busAck;

    // Byte-serial CRC of the firmware store, MSB first
    always_comb begin
        crcNext = crc_q ^ {fwData, 8'h00};
        for (int b = 0; b < 8; b++) begin
            crcNext = crcNext[15] ? ((crcNext << 1) ^ `TBSL_CRC_POLY) : (crcNext << 1);
        end
    end

    // Abort request held until the cycle in flight completes
    always_ff @(posedge mclk) begin
        if (rst || state_q == TBSL_IDLE) begin
            abortPend_q <= 1'b0;
        end else if (abortReq) begin
            abortPend_q <= 1'b1; // (R12)
        end
    end

    // Loop sequencer and target bus drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= TBSL_IDLE;
            cmd_q <= 6'h00;
            phase_q <= 1'b0;
            busWrite <= 1'b0;
            busIo <= 1'b0;
            busWord <= 1'b0;
            memory_space_select <= 3'h0;
            busAddr <= 20'h00000;
            busWdata <= 16'h0000;
            rejected_q <= 1'b0;
            crcErr_q <= 1'b0;
            crcDone_q <= 1'b0;
            crc_q <= `TBSL_CRC_INIT;
            fwAddr <= 12'h000;
        end else begin
            case (state_q)
                TBSL_IDLE: begin
                    if (startReq && !paused) begin
                        rejected_q <= 1'b1; // (R11)
                    end else if (startReq) begin
                        // Loop settings taken at start; toggle data, range start and range end are still read from the registers while running
                        rejected_q <= 1'b0;
                        cmd_q <= baseCmd;
                        phase_q <= 1'b0;
                        busIo <= ctrlIn[5:0] >= `TBSL_IO_BASE; // (R2)
                        busWord <= ctrlIn[`TBSL_CTRL_WORD]; // (R10)
                        memory_space_select <= ctrlIn[13:11]; // (R1)
                        busAddr <= addr_q; // (R7)
                        busWrite <= (baseCmd != TBSL_RANGE);
                        busWdata <= (baseCmd == TBSL_TOGGLE) ? 16'h0000 : // (R9)
                            (data_q & (ctrlIn[`TBSL_CTRL_WORD] ? 16'hffff : 16'h00ff));
                        crc_q <= `TBSL_CRC_INIT;
                        fwAddr <= 12'h000;
                        crcErr_q <= 1'b0;
                        crcDone_q <= 1'b0;
                        case (baseCmd)
                            TBSL_TOGGLE, TBSL_POKE, TBSL_ALT, TBSL_ROT, TBSL_WRRD, TBSL_INC,
                            TBSL_RANGE: state_q <= TBSL_BUS;
                            TBSL_SELF: state_q <= TBSL_CRC;
                            default: rejected_q <= 1'b1;
                        endcase
                    end
                end
                TBSL_BUS: begin
                    if (ack) begin
                        phase_q <= !phase_q;
                        if (abortPend_q || abortReq) begin
                            state_q <= TBSL_IDLE; // (R14)
                        end
                        case (cmd_q)
                            TBSL_ALT: busWdata <= ~busWdata & mask; // (R3)
                            TBSL_ROT: busWdata <= busWord ? {busWdata[14:0], busWdata[15]} :
                                {8'h00, busWdata[6:0], busWdata[7]}; // (R4)
                            TBSL_WRRD: busWrite <= phase_q; // (R5)
                            TBSL_INC: busWdata <= (busWdata + 16'h0001) & mask; // (R6)
                            TBSL_RANGE: busAddr <= (busAddr == end_q) ? addr_q : busAddr + 20'h00001; // (R8)
                            TBSL_TOGGLE: busWdata <= phase_q ? 16'h0000 : data_q & mask; // (R9)
                            default: ; // Poke repeats as is (R1)
                        endcase
                    end
                end
                TBSL_CRC: begin
                    crc_q <= crcNext;
                    fwAddr <= fwAddr + 12'h001;
                    if (fwAddr == `TBSL_FW_LAST) begin
                        // Single pass only; abort is not needed to end it
                        state_q <= TBSL_IDLE;
                        crcErr_q <= (crcNext != cref_q); // (R13)
                        crcDone_q <= 1'b1;
                    end
                end
                default: state_q <= TBSL_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Abort armed while a cycle is still waiting for its acknowledge
    sequence seqAbortWait;
        busReq && !busAck && (abortPend_q || abortReq);
    endsequence
    // Abort armed in the cycle that completes
    sequence seqAbortDone;
        busReq && busAck && (abortPend_q || abortReq);
    endsequence

    AST_REJECT: assert property (state_q == TBSL_IDLE && startReq && !paused |=> // (R11)
        rejected_q && state_q == TBSL_IDLE) else $error("start while running not rejected");
    AST_POKE: assert property (ack && cmd_q == TBSL_POKE |=> // (R1)
        busWdata == $past(busWdata) && busAddr == $past(busAddr)) else $error("poke changed");
    AST_IO: assert property ($rose(busReq) |-> busIo == (ctrl_q[5:0] >= `TBSL_IO_BASE)) // (R2)
        else $error("wrong space");
    AST_ALT: assert property (ack && cmd_q == TBSL_ALT |=> // (R3)
        busWdata == (~$past(busWdata) & mask)) else $error("alternate pair broken");
    AST_ROT: assert property (ack && cmd_q == TBSL_ROT && busWord |=> // (R4)
        busWdata == {$past(busWdata[14:0]), $past(busWdata[15])}) else $error("rotate wrong");
    AST_WRRD: assert property (ack && cmd_q == TBSL_WRRD && busWrite |=> // (R5)
        !busWrite && busAddr == $past(busAddr)) else $error("read not after write");
    AST_INC: assert property (ack && cmd_q == TBSL_INC |=> // (R6)
        busWdata == (($past(busWdata) + 16'h0001) & mask)) else $error("increment wrong");
    AST_WRAP: assert property (ack && cmd_q == TBSL_RANGE && busAddr == end_q |=> // (R8)
        busAddr == addr_q) else $error("range did not wrap");
    AST_STEP: assert property (ack && cmd_q == TBSL_RANGE && busAddr != end_q |=> // (R7)
        busAddr == $past(busAddr) + 20'h00001) else $error("range step wrong");
    AST_BYTE: assert property (busReq && !busWord |-> busWdata[15:8] == 8'h00) // (R10)
        else $error("byte mode upper bits set");
    AST_ABORT: assert property (seqAbortDone |=> // (R14)
        state_q == TBSL_IDLE) else $error("abort not honoured");
    AST_HOLD: assert property (seqAbortWait |=> busReq) // (R14)
        else $error("cycle cut short by abort");
    AST_CRC: assert property (state_q == TBSL_CRC && fwAddr == `TBSL_FW_LAST |=> // (R13)
        crcDone_q && state_q == TBSL_IDLE) else $error("crc pass not single");
endmodule // tbsl_exerciser
`default_nettype wire

// ---- hdl/tbsl_pkg.sv ----
// Types of the scope loop exerciser
`default_nettype none
package tbsl_pkg;
    typedef enum logic [1:0] {
        TBSL_IDLE = 2'b00,
        TBSL_BUS = 2'b01,
        TBSL_CRC = 2'b10
    } tbsl_state_t;
    typedef enum logic [5:0] {
        TBSL_TOGGLE = 6'h04,
        TBSL_POKE = 6'h06,
        TBSL_ALT = 6'h07,
        TBSL_ROT = 6'h08,
        TBSL_WRRD = 6'h09,
        TBSL_INC = 6'h0b,
        TBSL_RANGE = 6'h0c,
        TBSL_SELF = 6'h0d
    } tbsl_cmd_t;
endpackage : tbsl_pkg
`default_nettype wire

// ---- hdl/tbsl_regs.svh ----
// Register offsets, fields, reset values and counts of the scope loop exerciser
`ifndef TBSL_REGS_SVH
`define TBSL_REGS_SVH
`define TBSL_OFF_CTRL 8'h00
`define TBSL_OFF_ADDR 8'h04
`define TBSL_OFF_DATA 8'h08
`define TBSL_OFF_END 8'h0c
`define TBSL_OFF_STAT 8'h10
`define TBSL_OFF_CREF 8'h14
`define TBSL_CTRL_START 8
`define TBSL_CTRL_ABORT 9
`define TBSL_CTRL_WORD 10
`define TBSL_IO_BASE 6'h14
`define TBSL_CTRL_RST 32'h0000_0000
`define TBSL_CRC_INIT 16'hffff
`define TBSL_CRC_POLY 16'h1021
`define TBSL_FW_LAST 12'hfff
`define TBSL_RESP_OK 2'h0
`define TBSL_RESP_ERR 2'h2
`endif

// ---- sim/tb_top.sv ----
// Self-checking bench for the scope loop exerciser
`timescale 1ns/100ps
`default_nettype none
`include "tbsl_regs.svh"
module tb_top
    import tbsl_pkg::*;
;
    typedef struct packed {logic w; logic io; logic wd; logic [2:0] ms; logic [19:0] a; logic [15:0] d;} tbsl_cyc_t;
    localparam logic [19:0] loopAddr = 20'h00a3c;
    localparam logic [19:0] loopEnd = 20'h00a3f;
    localparam logic [15:0] loopData = 16'hc305;
    logic mclk = 1'h0, rst = 1'h1, paused = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, ackWait = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic busReq, busWrite, busIo, busWord, busAck;
    logic [2:0] memory_space_select;
    logic [19:0] busAddr;
    logic [15:0] busWdata;
    logic [11:0] fwAddr;
    logic [7:0] fwData;
    int failures = 0, tests_run = 0;
    tbsl_cyc_t seen[$];

    always #12.5 mclk = ~mclk;
    tbsl_exerciser DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .paused, .busReq, .busWrite,
        .busIo, .busWord, .memory_space_select, .busAddr, .busWdata, .busAck, .fwAddr, .fwData);
    tbsl_target_model target (.mclk, .rst, .busReq, .ackWait, .busAck);
    // Firmware store contents, cheap to recompute for the expected checksum
    function automatic logic [7:0] fwByte(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction
    assign fwData = fwByte(fwAddr);
    // Log every completed target bus cycle
    always @(posedge mclk) begin
        if (!rst && busReq === 1'h1 && busAck === 1'h1) begin
            seen.push_back({busWrite, busIo, busWord, memory_space_select, busAddr, busWrite ? busWdata : 16'h0});
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic guard(input int n);
        if (n > 5000) begin
            failures++;
            $display("ERROR %0t wait limit reached", $time);
            summarize();
        end
    endtask
    // Master holds bready and rready high throughout, so only valids move
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge mclk);
            guard(++n);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask
    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge mclk);
            guard(++n);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    function automatic logic [31:0] ctl(input logic [5:0] c, input logic wd, input logic [2:0] ms, input logic ab);
        return {18'h0, ms, wd, ab, ~ab, 2'h0, c};
    endfunction
    // Expected i-th cycle of a loop; read cycles are logged with zero data
    function automatic tbsl_cyc_t expCyc(input logic [5:0] c, input logic wd, input logic [2:0] ms, input int i);
        tbsl_cyc_t x;
        logic [15:0] m;
        m = wd ? 16'hffff : 16'h00ff;
        x = '{w: 1'h1, io: c >= `TBSL_IO_BASE, wd: wd, ms: ms, a: loopAddr, d: loopData & m};
        case (c >= `TBSL_IO_BASE ? c - `TBSL_IO_BASE : c)
            TBSL_TOGGLE: x.d = i[0] ? x.d : 16'h0;
            TBSL_ALT: x.d = i[0] ? ~x.d & m : x.d;
            TBSL_ROT: repeat (i) x.d = wd ? {x.d[14:0], x.d[15]} : {8'h0, x.d[6:0], x.d[7]};
            TBSL_WRRD: x.w = ~i[0];
            TBSL_INC: x.d = 16'(loopData + i) & m;
            TBSL_RANGE: begin
                x.w = 1'h0;
                x.a = loopAddr + 20'(i % int'(loopEnd - loopAddr + 20'h1));
            end
            default: ;
        endcase
        if (!x.w) x.d = 16'h0;
        return x;
    endfunction
    function automatic logic [15:0] crcExp();
        logic [15:0] c;
        c = `TBSL_CRC_INIT;
        for (int i = 0; i < 4096; i++) begin
            c = c ^ {fwByte(12'(i)), 8'h0};
            repeat (8) c = c[15] ? {c[14:0], 1'h0} ^ `TBSL_CRC_POLY : {c[14:0], 1'h0};
        end
        return c;
    endfunction

    task automatic testRegs();
        logic [31:0] d;
        logic [1:0] r;
        axiRead(`TBSL_OFF_CTRL, d, r);
        chk(48'(d), 48'(`TBSL_CTRL_RST), "control after reset");
        axiRead(`TBSL_OFF_STAT, d, r);
        chk(48'(d), 48'h0, "status after reset");
        axiRead(8'h18, d, r);
        chk(48'({r, d}), 48'({`TBSL_RESP_ERR, 32'h0}), "unmapped read");
        axiWrite(8'h18, 32'h1, r);
        chk(48'(r), 48'(`TBSL_RESP_ERR), "unmapped write");
    endtask
    task automatic testReject();
        logic [31:0] d;
        logic [1:0] r;
        axiWrite(`TBSL_OFF_CTRL, ctl(6'h05, 1'h0, 3'h0, 1'h0), r);
        axiRead(`TBSL_OFF_STAT, d, r);
        chk(48'(d[1:0]), 48'h2, "unknown loop refused");
        // An accepted run clears the flag, so the refusal below is seen afresh
        runLoop(TBSL_POKE, 1'h1, 3'h1, 4'h1);
        axiRead(`TBSL_OFF_STAT, d, r);
        chk(48'(d[1:0]), 48'h0, "rejected cleared by start");
        paused <= 1'h0;
        axiWrite(`TBSL_OFF_CTRL, ctl(TBSL_POKE, 1'h0, 3'h0, 1'h0), r);
        chk(48'(busReq), 48'h0, "bus idle while running");
        axiRead(`TBSL_OFF_STAT, d, r);
        chk(48'(d[1:0]), 48'h2, "start refused while running");
        paused <= 1'h1;
    endtask
    // Run a loop at least ten cycles, abort it from the host and check every cycle seen
    task automatic runLoop(input logic [5:0] c, input logic wd, input logic [2:0] ms, input logic [3:0] w);
        logic [1:0] r;
        int n, k;
        n = 0;
        ackWait <= w;
        axiWrite(`TBSL_OFF_ADDR, {12'h0, loopAddr}, r);
        axiWrite(`TBSL_OFF_DATA, {16'h0, loopData}, r);
        axiWrite(`TBSL_OFF_END, {12'h0, loopEnd}, r);
        seen.delete();
        axiWrite(`TBSL_OFF_CTRL, ctl(c, wd, ms, 1'h0), r);
        while (seen.size() < 10) begin
            @(posedge mclk);
            guard(++n);
        end
        axiWrite(`TBSL_OFF_CTRL, ctl(c, wd, ms, 1'h1), r);
        k = seen.size();
        while (busReq !== 1'h0) begin
            @(posedge mclk);
            guard(++n);
        end
        chk(48'(seen.size() <= k + 1), 48'h1, "cycles after abort");
        foreach (seen[i]) chk(48'(seen[i]), 48'(expCyc(c, wd, ms, i)), "bus cycle");
    endtask
    task automatic testLoops();
        logic [5:0] cmds[7] = '{TBSL_TOGGLE, TBSL_POKE, TBSL_ALT, TBSL_ROT, TBSL_WRRD, TBSL_INC, TBSL_RANGE};
        for (int k = 0; k < 7; k++) begin
            runLoop(cmds[k], k[0], 3'h5, 4'h0);
            runLoop(cmds[k] + `TBSL_IO_BASE, ~k[0], 3'h2, 4'h3);
        end
    endtask
    // Good reference first, then one that is off by a bit
    task automatic testCrc();
        logic [31:0] d;
        logic [1:0] r;
        int n;
        for (int bad = 0; bad < 2; bad++) begin
            axiWrite(`TBSL_OFF_CREF, {16'h0, crcExp() ^ 16'(bad)}, r);
            axiWrite(`TBSL_OFF_CTRL, ctl(TBSL_SELF, 1'h0, 3'h0, 1'h0), r);
            n = 0;
            do begin
                axiRead(`TBSL_OFF_STAT, d, r);
                guard(++n);
            end while (d[0] !== 1'h0);
            chk(48'(d[3:0]), 48'({1'h1, bad[0], 2'h0}), "self-check status");
        end
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        testRegs();
        testReject();
        testLoops();
        testCrc();
        summarize();
    end
endmodule // tb_top
`default_nettype wire

// ---- sim/tbsl_target_model.sv ----
// Target bus responder that acknowledges each cycle after a set wait
`timescale 1ns/100ps
`default_nettype none
module tbsl_target_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic busReq,
    input wire logic [3:0] ackWait,
    output logic busAck
);
    logic [3:0] waitCnt_q;
    // One-clock acknowledge; never two in a row, so each new cycle is seen first
    always_ff @(posedge mclk) begin
        if (rst || !busReq || busAck) begin
            busAck <= 1'h0;
            waitCnt_q <= 4'h0;
        end else if (waitCnt_q >= ackWait) begin
            busAck <= 1'h1;
        end else begin
            waitCnt_q <= waitCnt_q + 4'h1;
        end
    end
endmodule // tbsl_target_model
`default_nettype wire
